// ### shared/deep_sleep_regs.vh
// Constants for the deep sleep entry controller
`ifndef DEEP_SLEEP_REGS_VH
`define DEEP_SLEEP_REGS_VH

// ==================================================
// Unlock keys
`define DS_KEY_FIRST 8'h55
`define DS_KEY_SECOND 8'hAA

// ==================================================
// Control register fields
`define DS_CTRL_ARM_BIT 15
`define DS_CTRL_RELEASE_BIT 0
`define DS_CTRL_RESET 16'h0000

// ==================================================
// Configuration word fields
`define DS_CFG_BOR_BIT 6

// ==================================================
// Wake cause fields
`define DS_WAKE_POR_BIT 0
`define DS_WAKE_MASTER_CLR_BIT 1
`define DS_WAKE_ALARM_BIT 2
`define DS_WAKE_INT0_BIT 3
`define DS_WAKE_WDT_BIT 4
`define DS_WAKE_ULPW_BIT 5
`define DS_WAKE_RESET 8'h01

// ==================================================
// Power save operand selecting sleep
`define DS_SLEEP_OPERAND 8'h00

// ==================================================
// Timing
`define DS_CLK_PERIOD_NS 50
`define DS_CLK_PER_TCY 1
`define DS_REENTRY_TCY 3
`define DS_REENTRY_CYCLES (`DS_REENTRY_TCY * `DS_CLK_PER_TCY)
`define DS_WDT_TIMEOUT_CYCLES 32'd8192

`endif

// ### design/ds_pin_sync.v
// Two flip-flop synchroniser for a group of asynchronous pins
module ds_pin_sync #(
    parameter WIDTH = 4
) (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;

    // ==================================================
    // Synchroniser stages
    // First stage feeds only the second stage
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else if (ce)
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // ds_pin_sync

// ### design/deep_sleep_entry_control.v
// Deep sleep arming, entry, exit and retention control
// Summary of operation
// - Enter deep sleep: arm, then sleep instruction
// - Arm needs keys 55 then AA first
// - Armed state never times out
// - Hardware clears arm on deep sleep exit
// - Setting arm clears all wake causes
// - Arm bit sits at control bit 15
// - Config word bit 6 enables brown-out
// - Two scratch registers survive deep sleep
// - Listed reset and wake events end sleep
// - Calendar keeps running through deep sleep
`include "deep_sleep_regs.vh"

module deep_sleep_entry_control #(
    parameter [31:0] WDT_TIMEOUT_CYCLES = `DS_WDT_TIMEOUT_CYCLES
) (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire key_wr,
    input wire [7:0] key_data,
    input wire arm_set,
    input wire arm_clr,
    input wire release_clr,
    input wire power_save_instr,
    input wire [7:0] power_save_operand,
    input wire [7:0] deep_sleep_config_word,
    input wire watchdog_enable,
    input wire calendar_enable,
    input wire master_clear_pin,
    input wire calendar_alarm,
    input wire ext_int0,
    input wire ultra_low_power_wake,
    input wire [1:0] scratch_wr,
    input wire [15:0] scratch_wdata,
    output reg deep_sleep_arm,
    output reg [15:0] deep_sleep_control_reg,
    output reg [7:0] wake_cause_reg,
    output reg deep_sleep_brownout_enable,
    output reg [15:0] retained_scratch_0,
    output reg [15:0] retained_scratch_1,
    output reg in_deep_sleep,
    output reg core_wake,
    output reg pin_hold,
    output reg calendar_run,
    output reg entry_refused
);

    // ==================================================
    // Local encodings
    localparam [1:0] ST_RUN = 2'd0;
    localparam [1:0] ST_SLEEP = 2'd1;
    localparam [1:0] ST_EXIT = 2'd2;
    localparam [1:0] KEY_IDLE = 2'd0;
    localparam [1:0] KEY_FIRST = 2'd1;
    localparam [1:0] KEY_OPEN = 2'd2;
    localparam [31:0] GUARD_FULL = `DS_REENTRY_CYCLES;
    localparam [1:0] GUARD_LOAD = GUARD_FULL[1:0];

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [1:0] key_q;
    reg [1:0] key_d;
    reg arm_q;
    reg arm_d;
    reg hold_q;
    reg hold_d;
    reg [1:0] guard_q;
    reg [1:0] guard_d;
    reg [7:0] wake_q;
    reg [7:0] wake_d;
    reg [31:0] wdt_q;
    reg [31:0] wdt_d;
    reg cfg_loaded_q;
    reg wake_any;
    reg wdt_expired;
    reg [7:0] wake_events;
    reg sleep_req;
    reg arm_take;
    wire [3:0] pins_sync;

    // ==================================================
    // Pin synchronisers: master clear, alarm, int0, ulp wake
    ds_pin_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .async_in({ultra_low_power_wake, ext_int0, calendar_alarm, master_clear_pin}),
        .sync_out(pins_sync)
    );

    // ==================================================
    // Unlock key sequencer
    always @*
    begin
        key_d = key_q;
        if (key_wr)
        begin
            if (key_data == `DS_KEY_FIRST)
                key_d = KEY_FIRST;
            else if (key_data == `DS_KEY_SECOND && key_q == KEY_FIRST)
                key_d = KEY_OPEN;
            else
                key_d = KEY_IDLE;
        end
        else if (arm_set)
            key_d = KEY_IDLE; // Unlock used up by any arm attempt
    end

    // ==================================================
    // Wake event collection while asleep
    always @*
    begin
        wdt_expired = watchdog_enable && (wdt_q >= WDT_TIMEOUT_CYCLES - 32'd1);
        wake_events = 8'h00;
        if (state_q == ST_SLEEP)
        begin
            wake_events[`DS_WAKE_MASTER_CLR_BIT] = pins_sync[0];
            wake_events[`DS_WAKE_ALARM_BIT] = pins_sync[1];
            wake_events[`DS_WAKE_INT0_BIT] = pins_sync[2];
            wake_events[`DS_WAKE_WDT_BIT] = wdt_expired;
            wake_events[`DS_WAKE_ULPW_BIT] = pins_sync[3];
        end
        wake_any = |wake_events;
    end

    // ==================================================
    // Arm bit, entry request and watchdog counter
    always @*
    begin
        arm_take = arm_set && (key_q == KEY_OPEN) && (state_q == ST_RUN);
        sleep_req = power_save_instr && (power_save_operand == `DS_SLEEP_OPERAND)
                    && arm_q && (guard_q == 2'd0) && (state_q == ST_RUN);
        arm_d = arm_q; // No timeout while armed
        if (state_q == ST_SLEEP && wake_any)
            arm_d = 1'b0;
        else if (arm_take)
            arm_d = 1'b1;
        else if (arm_clr && state_q == ST_RUN)
            arm_d = 1'b0;
        wdt_d = 32'd0;
        if (state_q == ST_SLEEP && watchdog_enable && !wake_any)
            wdt_d = wdt_q + 32'd1;
    end

    // ==================================================
    // Wake causes: new events win over the arm clear
    always @*
    begin
        wake_d = wake_q;
        if (arm_take)
            wake_d = 8'h00;
        wake_d = wake_d | wake_events;
    end

    // ==================================================
    // Sleep state machine, pin hold and re-entry guard
    always @*
    begin
        state_d = state_q;
        hold_d = hold_q;
        guard_d = guard_q;
        if (guard_q != 2'd0)
            guard_d = guard_q - 2'd1;
        case (state_q)
            ST_RUN:
            begin
                if (sleep_req)
                    state_d = ST_SLEEP;
                if (release_clr && hold_q)
                begin
                    hold_d = 1'b0;
                    guard_d = GUARD_LOAD; // Hold-off before re-entry
                end
            end
            ST_SLEEP:
            begin
                if (wake_any)
                begin
                    state_d = ST_EXIT;
                    hold_d = 1'b1;
                end
            end
            ST_EXIT:
                state_d = ST_RUN;
            default:
                state_d = ST_RUN;
        endcase
    end

    // ==================================================
    // Control state registers
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ST_RUN;
            key_q <= KEY_IDLE;
            arm_q <= 1'b0;
            hold_q <= 1'b0;
            guard_q <= 2'd0;
            wake_q <= `DS_WAKE_RESET;
            wdt_q <= 32'd0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            key_q <= key_d;
            arm_q <= arm_d;
            hold_q <= hold_d;
            guard_q <= guard_d;
            wake_q <= wake_d;
            wdt_q <= wdt_d;
        end
    end

    // ==================================================
    // Retained scratch, cleared only by power-on reset
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            retained_scratch_0 <= 16'h0000;
            retained_scratch_1 <= 16'h0000;
        end
        else if (ce)
        begin
            if (scratch_wr[0])
                retained_scratch_0 <= scratch_wdata;
            if (scratch_wr[1])
                retained_scratch_1 <= scratch_wdata;
        end
    end

    // ==================================================
    // Configuration word captured once after reset release
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_loaded_q <= 1'b0;
            deep_sleep_brownout_enable <= 1'b0;
        end
        else if (ce && !cfg_loaded_q)
        begin
            cfg_loaded_q <= 1'b1;
            deep_sleep_brownout_enable <= deep_sleep_config_word[`DS_CFG_BOR_BIT];
        end
    end

    // ==================================================
    // Registered outputs
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            deep_sleep_arm <= 1'b0;
            deep_sleep_control_reg <= `DS_CTRL_RESET;
            wake_cause_reg <= `DS_WAKE_RESET;
            in_deep_sleep <= 1'b0;
            core_wake <= 1'b0;
            pin_hold <= 1'b0;
            calendar_run <= 1'b0;
            entry_refused <= 1'b0;
        end
        else if (ce)
        begin
            deep_sleep_arm <= arm_d;
            deep_sleep_control_reg <= `DS_CTRL_RESET;
            deep_sleep_control_reg[`DS_CTRL_ARM_BIT] <= arm_d;
            deep_sleep_control_reg[`DS_CTRL_RELEASE_BIT] <= hold_d;
            wake_cause_reg <= wake_d;
            in_deep_sleep <= (state_d == ST_SLEEP);
            core_wake <= (state_q == ST_SLEEP) && wake_any;
            pin_hold <= hold_d;
            calendar_run <= calendar_enable; // Not gated by sleep state
            entry_refused <= power_save_instr && (power_save_operand == `DS_SLEEP_OPERAND)
                             && (state_q == ST_RUN) && !sleep_req;
        end
    end

endmodule // deep_sleep_entry_control

// ### testbench/deep_sleep_entry_control_asserts.sv
// Port-level assertions for the deep sleep entry controller
module deep_sleep_entry_control_asserts (
    input logic clk,
    input logic rstn,
    input logic arm_set,
    input logic arm_clr,
    input logic power_save_instr,
    input logic [7:0] power_save_operand,
    input logic [7:0] deep_sleep_config_word,
    input logic [1:0] scratch_wr,
    input logic deep_sleep_arm,
    input logic [15:0] deep_sleep_control_reg,
    input logic [7:0] wake_cause_reg,
    input logic deep_sleep_brownout_enable,
    input logic [15:0] retained_scratch_0,
    input logic [15:0] retained_scratch_1,
    input logic in_deep_sleep,
    input logic core_wake,
    input logic pin_hold
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ====
    // Arming, entry, exit, scratch retention and brown-out configuration
    chk_arm_needs_set: assert property ($rose(deep_sleep_arm) |-> $past(arm_set))
        else $error("arm rose without a set request");
    chk_wake_cleared: assert property ($rose(deep_sleep_arm) |-> wake_cause_reg == 8'h00)
        else $error("wake causes not cleared on arm");
    chk_ctrl_layout: assert property (deep_sleep_control_reg == {deep_sleep_arm, 14'h0000, pin_hold})
        else $error("control register layout wrong");
    chk_entry_armed: assert property ($rose(in_deep_sleep) |->
        $past(deep_sleep_arm) && $past(power_save_instr) && $past(power_save_operand) == 8'h00)
        else $error("sleep entered without arm and operand zero");
    chk_exit_effects: assert property ($fell(in_deep_sleep) |-> core_wake && !deep_sleep_arm && pin_hold)
        else $error("exit without wake pulse, arm clear and hold");
    chk_wake_pulse: assert property (core_wake |=> !core_wake)
        else $error("wake pulse longer than one cycle");
    chk_arm_kept: assert property ($fell(deep_sleep_arm) |-> core_wake || $past(arm_clr))
        else $error("arm dropped without cause");
    chk_scratch_kept: assert property (scratch_wr == 2'b00 |=>
        $stable(retained_scratch_0) && $stable(retained_scratch_1))
        else $error("scratch changed without write");
    chk_bor_config: assert property ($changed(deep_sleep_brownout_enable) |->
        deep_sleep_brownout_enable == deep_sleep_config_word[6])
        else $error("brown-out enable differs from config bit");
    chk_reentry_guard: assert property ($fell(pin_hold) |-> ##1 !in_deep_sleep [*3])
        else $error("sleep entered inside release guard");

    // ====
    // Main scenarios
    cov_arm: cover property ($rose(deep_sleep_arm));
    cov_entry: cover property ($rose(in_deep_sleep));
    cov_release: cover property ($fell(pin_hold));
endmodule // deep_sleep_entry_control_asserts

bind deep_sleep_entry_control deep_sleep_entry_control_asserts deep_sleep_entry_control_asserts_inst (
    .clk, .rstn, .arm_set, .arm_clr, .power_save_instr, .power_save_operand, .deep_sleep_config_word, .scratch_wr,
    .deep_sleep_arm, .deep_sleep_control_reg, .wake_cause_reg, .deep_sleep_brownout_enable,
    .retained_scratch_0, .retained_scratch_1, .in_deep_sleep, .core_wake, .pin_hold
);

// ### testbench/deep_sleep_entry_control_tb_top.sv
// Self-checking testbench for the deep sleep entry controller
module deep_sleep_entry_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, ce, key_wr, arm_set, arm_clr, release_clr, power_save_instr, watchdog_enable, calendar_enable;
    logic [7:0] key_data, power_save_operand, deep_sleep_config_word, wake_cause_reg;
    logic [3:0] pins;
    logic [1:0] scratch_wr;
    logic [15:0] scratch_wdata, deep_sleep_control_reg, retained_scratch_0, retained_scratch_1;
    logic deep_sleep_arm, deep_sleep_brownout_enable, in_deep_sleep, core_wake, pin_hold, calendar_run, entry_refused;
    int n_fail = 0;
    int tests_run = 0;
    int wbit [5] = '{1, 2, 3, 5, 4};

    deep_sleep_entry_control #(.WDT_TIMEOUT_CYCLES(32'd8)) deep_sleep_entry_control_inst (
        .clk, .rstn, .ce, .key_wr, .key_data, .arm_set, .arm_clr, .release_clr, .power_save_instr,
        .power_save_operand, .deep_sleep_config_word, .watchdog_enable, .calendar_enable,
        .master_clear_pin(pins[0]), .calendar_alarm(pins[1]), .ext_int0(pins[2]), .ultra_low_power_wake(pins[3]),
        .scratch_wr, .scratch_wdata, .deep_sleep_arm, .deep_sleep_control_reg, .wake_cause_reg,
        .deep_sleep_brownout_enable, .retained_scratch_0, .retained_scratch_1, .in_deep_sleep, .core_wake,
        .pin_hold, .calendar_run, .entry_refused
    );

    // ====
    // Clock and watchdog
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        #(50 * 3000);
        n_fail++;
        summarize();
    end

    // ====
    // Access tasks
    // One strobe for one cycle; kinds: key, arm, arm clear, sleep, release, scratch 0, scratch 1
    task automatic op(input int k, input logic [15:0] d);
        @(posedge clk);
        {key_data, power_save_operand, scratch_wdata} <= {d[7:0], d[7:0], d};
        case (k)
            0: key_wr <= 1'b1;
            1: arm_set <= 1'b1;
            2: arm_clr <= 1'b1;
            3: power_save_instr <= 1'b1;
            4: release_clr <= 1'b1;
            default: scratch_wr <= (k == 5) ? 2'b01 : 2'b10;
        endcase
        @(posedge clk);
        {key_wr, arm_set, arm_clr, power_save_instr, release_clr, scratch_wr} <= '0;
        #1;
    endtask

    task automatic unlock();
        op(0, 16'h0055);
        op(0, 16'h00AA);
        op(1, 16'h0000);
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d failures=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ====
    // Test sequence
    initial
    begin
        {rstn, key_wr, arm_set, arm_clr, release_clr, power_save_instr, watchdog_enable} = '0;
        {ce, calendar_enable, pins, scratch_wr} = 8'hC0;
        {key_data, power_save_operand, deep_sleep_config_word, scratch_wdata} = 40'h00_0040_0000;
        repeat (2) @(posedge clk);
        check(16'(wake_cause_reg), 16'h0001);
        rstn <= 1'b1;
        op(1, 16'h0000);
        check(16'(deep_sleep_brownout_enable), 16'h0001);
        check(16'(deep_sleep_arm), 16'h0000);
        op(0, 16'h00AA);
        op(0, 16'h0055);
        op(1, 16'h0000);
        check(16'(deep_sleep_arm), 16'h0000);
        op(0, 16'h0055);
        op(0, 16'h0033);
        op(0, 16'h00AA);
        op(1, 16'h0000);
        check(16'(deep_sleep_arm), 16'h0000);
        unlock();
        check(deep_sleep_control_reg, 16'h8000);
        check(16'(wake_cause_reg), 16'h0000);
        // Clock enable low: a clear request must not touch the arm bit
        @(posedge clk);
        ce <= 1'b0;
        op(2, 16'h0000);
        check(16'(deep_sleep_arm), 16'h0001);
        @(posedge clk);
        ce <= 1'b1;
        op(2, 16'h0000);
        check(16'(deep_sleep_arm), 16'h0000);
        op(5, 16'hA5C3);
        op(6, 16'h3C5A);
        op(3, 16'h0000);
        check(16'(entry_refused), 16'h0001);
        // One pass per wake source, the last by the deep sleep watchdog
        for (int i = 0; i < 5; i++)
        begin
            unlock();
            repeat (20) @(posedge clk);
            check(16'(deep_sleep_arm), 16'h0001);
            op(3, 16'h0001);
            check(16'(in_deep_sleep), 16'h0000);
            op(3, 16'h0000);
            check(16'(in_deep_sleep), 16'h0001);
            check(16'(calendar_run), 16'h0001);
            @(posedge clk);
            if (i < 4)
                pins[i] <= 1'b1;
            else
                watchdog_enable <= 1'b1;
            for (int n = 0; n < 40 && core_wake !== 1'b1; n++)
            begin
                @(posedge clk);
                #1;
            end
            check(16'(core_wake), 16'h0001);
            check(16'(wake_cause_reg), 16'h0001 << wbit[i]);
            check(deep_sleep_control_reg, 16'h0001);
            check(retained_scratch_0, 16'hA5C3);
            check(retained_scratch_1, 16'h3C5A);
            @(posedge clk);
            {pins, watchdog_enable} <= '0;
            // Re-arm first so that only the release guard can refuse the entry
            unlock();
            op(4, 16'h0000);
            op(3, 16'h0000);
            check(16'(entry_refused), 16'h0001);
            check(16'(in_deep_sleep), 16'h0000);
            repeat (4) @(posedge clk);
        end
        summarize();
    end
endmodule // deep_sleep_entry_control_tb_top
